//--- verilog/aot_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          measurement-option and temperature readout block.
// Assumes: One 250 MHz clock; registers are 8 bits wide.
// Notes:   Definitions only.
`ifndef AOT_DEFS_SVH
`define AOT_DEFS_SVH

// ============================================================
// Register offsets
`define AOT_REG_VOLT25      8'h20
`define AOT_REG_VSUPPLY     8'h22
`define AOT_REG_REMOTE1     8'h25
`define AOT_REG_LOCAL       8'h26
`define AOT_REG_REMOTE2     8'h27
`define AOT_REG_CHAN_SEL    8'h55
`define AOT_REG_CFG2        8'h73
`define AOT_REG_FRACTION    8'h77

// ============================================================
// Field positions
`define AOT_CFG2_AVG_OFF    4
`define AOT_CFG2_BYPASS     5
`define AOT_CFG2_SINGLE     6
`define AOT_SEL_MSB         7
`define AOT_SEL_LSB         5

// ============================================================
// Channel selector codes
`define AOT_CH_VOLT25       3'h0
`define AOT_CH_VSUPPLY      3'h2
`define AOT_CH_REMOTE1      3'h5
`define AOT_CH_LOCAL        3'h6
`define AOT_CH_REMOTE2      3'h7

// ============================================================
// Reset values
`define AOT_RST_TEMP        8'h80
`define AOT_RST_FRACTION    2'h0
`define AOT_RST_VOLT        8'h00
`define AOT_RST_CFG2        8'h00
`define AOT_RST_CHAN_SEL    8'hFF

// ============================================================
// Timing
`define AOT_CLK_PERIOD_NS   4
`define AOT_CONV_TIME_NS    711000
`define AOT_REMOTE_MEAS_NS  25500000
`define AOT_AVG_SAMPLES     16

`endif

//--- verilog/aot_pkg.sv
// Purpose: Types shared by the readout block.
// Assumes: Constants come from aot_defs.svh.
// Notes:   Types only.
package aot_pkg;

  // ============================================================
  // Sequencer states
  typedef enum logic [0:0] {
    AOT_ST_LAUNCH,
    AOT_ST_SETTLE
  } aot_state_type;

  // Selector code of a converter input
  typedef logic [2:0] aot_chan_type;

endpackage : aot_pkg

//--- verilog/aot_averager.sv
// Purpose: Sixteen-sample running accumulator with bypass.
// Assumes: Samples are 10 bits, signed or unsigned per sample.
// Notes:   Result is the floor of the mean; clear restarts the count.
`timescale 1ns/1ns
`default_nettype none
`include "aot_defs.svh"

module aot_averager
  import aot_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic avg_off_in,
  input wire logic is_signed_in,
  input wire logic sample_valid_in,
  input wire logic [9:0] sample_in,
  output logic result_valid_out,
  output logic [9:0] result_out
);

  logic [13:0] acc_q, acc_d;
  logic [3:0] cnt_q, cnt_d;
  logic [9:0] res_q, res_d;
  logic vld_q, vld_d;
  logic [13:0] ext;
  logic [13:0] sum;

  // ============================================================
  // Accumulate; extending the sign keeps the mean of negatives right
  always_comb begin
    ext = is_signed_in ? {{4{sample_in[9]}}, sample_in} : {4'h0, sample_in};
    sum = acc_q + ext;
    acc_d = acc_q;
    cnt_d = cnt_q;
    res_d = res_q;
    vld_d = 1'b0;
    if (clear_in) begin
      acc_d = 14'h0000;
      cnt_d = 4'h0;
    end else if (sample_valid_in) begin
      if (avg_off_in) begin
        res_d = sample_in;
        vld_d = 1'b1;
        acc_d = 14'h0000;
        cnt_d = 4'h0;
      end else if (cnt_q == 4'(`AOT_AVG_SAMPLES - 1)) begin
        res_d = sum[13:4];
        vld_d = 1'b1;
        acc_d = 14'h0000;
        cnt_d = 4'h0;
      end else begin
        acc_d = sum;
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  // Register state
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_q <= 14'h0000;
      cnt_q <= 4'h0;
      res_q <= 10'h000;
      vld_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      vld_q <= vld_d;
    end
  end

  assign result_valid_out = vld_q;
  assign result_out = res_q;

endmodule : aot_averager

`default_nettype wire

//--- verilog/aot_readout.sv
// Purpose: Measurement sequencing, option register and temperature result
//          registers with coherent fractional readout.
// Assumes: Register port is the internal side of the serial interface;
//          converter returns one sample per start within one slot.
// Notes:
// Operation
// - Voltage results are the mean of sixteen conversions by default.
// - Option bit four set stores single conversions, no averaging.
// - Unaveraged voltage reading finishes in one 711 us conversion.
// - Option bit five set bypasses the 2.5 V input attenuator.
// - Option bit six set converts only the selected channel.
// - Single-channel mode converts a selected voltage or local input every 711 us, a remote diode every 1593.75 us.
// - Selector field bits 7:5 at 0x55: 000 is 2.5 V, 010 supply.
// - Local temperature integer byte sits at 0x26, two's complement.
// - Temperature code spans -128 to +127 degrees, quarter-degree steps.
// - Remote temperature results are means of sixteen measurement cycles.
// - An averaged remote temperature measurement takes nominally 25.5 ms.
// - Fraction bits packed at 0x77: remote two 7:6, local 5:4, remote one 3:2.
// - Upper eight bits whole degrees, lower two quarter steps.
// - Integer temperature bytes readable any time, any order.
// - Fraction read freezes temperature registers until all are read.
// - An averaged voltage measurement takes nominally 11.38 ms.
`timescale 1ns/1ns
`default_nettype none
`include "aot_defs.svh"

module aot_readout
  import aot_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = `AOT_CONV_TIME_NS / `AOT_CLK_PERIOD_NS,
  parameter int unsigned REMOTE_SLOT_CYCLES =
    `AOT_REMOTE_MEAS_NS / `AOT_CLK_PERIOD_NS / `AOT_AVG_SAMPLES
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic adc_start_out,
  output logic [2:0] adc_chan_out,
  output logic attn_bypass_out,
  input wire logic adc_valid_in,
  input wire logic [9:0] adc_data_in
);

  // ============================================================
  // Configuration registers
  logic [7:0] cfg2_q, cfg2_d;
  logic [7:0] sel_q, sel_d;
  logic restart;
  logic avg_off;
  logic single_mode;
  aot_chan_type sel_code;

  assign avg_off = cfg2_q[`AOT_CFG2_AVG_OFF];
  assign single_mode = cfg2_q[`AOT_CFG2_SINGLE];
  assign sel_code = sel_q[`AOT_SEL_MSB:`AOT_SEL_LSB];

  // Writes; any option change restarts the running measurement
  always_comb begin
    cfg2_d = cfg2_q;
    sel_d = sel_q;
    restart = 1'b0;
    if (reg_wr_in && reg_addr_in == `AOT_REG_CFG2) begin
      cfg2_d = reg_wdata_in;
      restart = 1'b1;
    end
    if (reg_wr_in && reg_addr_in == `AOT_REG_CHAN_SEL) begin
      sel_d = reg_wdata_in;
      restart = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg2_q <= `AOT_RST_CFG2;
      sel_q <= `AOT_RST_CHAN_SEL;
    end else begin
      cfg2_q <= cfg2_d;
      sel_q <= sel_d;
    end
  end

  assign attn_bypass_out = cfg2_q[`AOT_CFG2_BYPASS];

  // ============================================================
  // Conversion sequencer
  aot_state_type state_q, state_d;
  aot_chan_type chan_q, chan_d;
  aot_chan_type chan_use;
  logic [18:0] timer_q, timer_d;
  logic start_q, start_d;
  logic [2:0] achan_q, achan_d;
  logic res_valid;
  logic [9:0] res_data;
  logic chan_is_temp;

  assign chan_is_temp = (chan_q == `AOT_CH_REMOTE1) || (chan_q == `AOT_CH_LOCAL) ||
                        (chan_q == `AOT_CH_REMOTE2);

  // Round-robin order: 2.5 V, supply, remote one, local, remote two
  function automatic aot_chan_type next_chan(input aot_chan_type c);
    aot_chan_type n;
    n = `AOT_CH_VOLT25;
    unique case (c)
      `AOT_CH_VOLT25: n = `AOT_CH_VSUPPLY;
      `AOT_CH_VSUPPLY: n = `AOT_CH_REMOTE1;
      `AOT_CH_REMOTE1: n = `AOT_CH_LOCAL;
      `AOT_CH_LOCAL: n = `AOT_CH_REMOTE2;
      default: n = `AOT_CH_VOLT25;
    endcase
    return n;
  endfunction : next_chan

  // One slot per conversion; remote diodes get the longer slot
  always_comb begin
    state_d = state_q;
    chan_d = chan_q;
    timer_d = timer_q;
    start_d = 1'b0;
    achan_d = achan_q;
    chan_use = single_mode ? sel_code : chan_q;
    if (restart) begin
      state_d = AOT_ST_LAUNCH;
    end else begin
      unique case (state_q)
        AOT_ST_LAUNCH: begin
          chan_d = chan_use;
          achan_d = chan_use;
          start_d = 1'b1;
          if (chan_use == `AOT_CH_REMOTE1 || chan_use == `AOT_CH_REMOTE2) begin
            timer_d = 19'(REMOTE_SLOT_CYCLES - 1);
          end else begin
            timer_d = 19'(CONV_CYCLES - 1);
          end
          state_d = AOT_ST_SETTLE;
        end
        AOT_ST_SETTLE: begin
          if (timer_q == 19'h0_0000) begin
            state_d = AOT_ST_LAUNCH;
          end else begin
            timer_d = timer_q - 19'h0_0001;
          end
          if (res_valid && !single_mode) begin
            chan_d = next_chan(chan_q);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= AOT_ST_LAUNCH;
      chan_q <= `AOT_CH_VOLT25;
      timer_q <= 19'h0_0000;
      start_q <= 1'b0;
      achan_q <= `AOT_CH_VOLT25;
    end else begin
      state_q <= state_d;
      chan_q <= chan_d;
      timer_q <= timer_d;
      start_q <= start_d;
      achan_q <= achan_d;
    end
  end

  assign adc_start_out = start_q;
  assign adc_chan_out = achan_q;

  // Averaging of sixteen samples, or pass-through when switched off
  aot_averager u_avg (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .clear_in(restart),
    .avg_off_in(avg_off),
    .is_signed_in(chan_is_temp),
    .sample_valid_in(adc_valid_in),
    .sample_in(adc_data_in),
    .result_valid_out(res_valid),
    .result_out(res_data)
  );

  // ============================================================
  // Voltage result registers; reserved codes never match a store
  logic [7:0] v25_q, v25_d;
  logic [7:0] vsup_q, vsup_d;

  always_comb begin
    v25_d = v25_q;
    vsup_d = vsup_q;
    if (res_valid && chan_q == `AOT_CH_VOLT25) begin
      v25_d = res_data[9:2];
    end
    if (res_valid && chan_q == `AOT_CH_VSUPPLY) begin
      vsup_d = res_data[9:2];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      v25_q <= `AOT_RST_VOLT;
      vsup_q <= `AOT_RST_VOLT;
    end else begin
      v25_q <= v25_d;
      vsup_q <= vsup_d;
    end
  end

  // ============================================================
  // Temperature results: entry 0 remote one, 1 local, 2 remote two
  logic [9:0] temp_q [3];
  logic [9:0] temp_d [3];
  logic [9:0] pend_q [3];
  logic [9:0] pend_d [3];
  logic [2:0] pendv_q, pendv_d;
  logic [2:0] rmask_q, rmask_d;
  logic freeze_q, freeze_d;
  logic frac_read;
  logic all_read;

  assign frac_read = reg_rd_in && reg_addr_in == `AOT_REG_FRACTION;
  assign all_read = &rmask_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_temp
      localparam aot_chan_type CODE = (gi == 0) ? `AOT_CH_REMOTE1 :
                                      (gi == 1) ? `AOT_CH_LOCAL : `AOT_CH_REMOTE2;
      localparam logic [7:0] ADDR = (gi == 0) ? `AOT_REG_REMOTE1 :
                                    (gi == 1) ? `AOT_REG_LOCAL : `AOT_REG_REMOTE2;
      logic hit;
      assign hit = res_valid && chan_q == CODE;

      // Frozen entries park new results; parked result lands on release
      always_comb begin
        temp_d[gi] = temp_q[gi];
        pend_d[gi] = pend_q[gi];
        pendv_d[gi] = pendv_q[gi];
        rmask_d[gi] = rmask_q[gi];
        if (freeze_q) begin
          if (hit) begin
            pend_d[gi] = res_data;
            pendv_d[gi] = 1'b1;
          end
        end else if (hit) begin
          temp_d[gi] = res_data;
          pendv_d[gi] = 1'b0;
        end else if (pendv_q[gi]) begin
          temp_d[gi] = pend_q[gi];
          pendv_d[gi] = 1'b0;
        end
        if (frac_read) begin
          rmask_d[gi] = 1'b0;
        end else if (reg_rd_in && reg_addr_in == ADDR) begin
          rmask_d[gi] = 1'b1;
        end
      end

      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          temp_q[gi] <= {`AOT_RST_TEMP, `AOT_RST_FRACTION};
          pend_q[gi] <= 10'h000;
          pendv_q[gi] <= 1'b0;
          rmask_q[gi] <= 1'b0;
        end else begin
          temp_q[gi] <= temp_d[gi];
          pend_q[gi] <= pend_d[gi];
          pendv_q[gi] <= pendv_d[gi];
          rmask_q[gi] <= rmask_d[gi];
        end
      end
    end
  endgenerate

  // Freeze is set by a fraction read, which wins over a release
  always_comb begin
    freeze_d = frac_read || (freeze_q && !all_read);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      freeze_q <= 1'b0;
    end else begin
      freeze_q <= freeze_d;
    end
  end

  // ============================================================
  // Read port; answer one cycle after the strobe, unmapped reads zero
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_in;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `AOT_REG_VOLT25: rdata_d = v25_q;
        `AOT_REG_VSUPPLY: rdata_d = vsup_q;
        `AOT_REG_REMOTE1: rdata_d = temp_q[0][9:2];
        `AOT_REG_LOCAL: rdata_d = temp_q[1][9:2];
        `AOT_REG_REMOTE2: rdata_d = temp_q[2][9:2];
        `AOT_REG_CHAN_SEL: rdata_d = sel_q;
        `AOT_REG_CFG2: rdata_d = cfg2_q;
        `AOT_REG_FRACTION: rdata_d = {temp_q[2][1:0], temp_q[1][1:0],
                                      temp_q[0][1:0], 2'h0};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;

endmodule : aot_readout

`default_nettype wire

//--- test/aot_readout_asserts.sv
// Purpose: Port checks on the readout block.
// Assumes: One clock, async active-low reset.
// Notes: Slot counts come in as parameters.
`timescale 1ns/1ns
`default_nettype none

module aot_readout_asserts #(
  parameter int unsigned CONV_CYCLES = 20,
  parameter int unsigned REMOTE_SLOT_CYCLES = 30
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic adc_start_out,
  input wire logic [2:0] adc_chan_out,
  input wire logic attn_bypass_out
);
  // ========
  // Helpers
  logic [19:0] gap_q, gap_d;
  logic armed_q, armed_d, cw_q, single_q, single_d;
  logic [2:0] chan_q, chan_d, sel_q, sel_d;
  logic cw;
  // A config write restarts the sequencer, so the slot it cuts short goes unchecked
  assign cw = reg_wr_in && (reg_addr_in == 8'h73 || reg_addr_in == 8'h55);
  always_comb begin
    gap_d = adc_start_out ? 20'h0_0001 : gap_q + 20'h0_0001;
    armed_d = (cw || cw_q) ? 1'h0 : (adc_start_out ? 1'h1 : armed_q);
    chan_d = adc_start_out ? adc_chan_out : chan_q;
    single_d = single_q;
    sel_d = sel_q;
    if (reg_wr_in && reg_addr_in == 8'h73) single_d = reg_wdata_in[6];
    if (reg_wr_in && reg_addr_in == 8'h55) sel_d = reg_wdata_in[7:5];
  end
  // Shadow state
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_q <= 20'h0_0000;
      armed_q <= 1'h0;
      cw_q <= 1'h0;
      chan_q <= 3'h0;
      single_q <= 1'h0;
      sel_q <= 3'h7;
    end else begin
      gap_q <= gap_d;
      armed_q <= armed_d;
      cw_q <= cw;
      chan_q <= chan_d;
      single_q <= single_d;
      sel_q <= sel_d;
    end
  end

  // ========
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence rd_s; reg_rd_in; endsequence
  sequence ans_s; ##1 reg_rvalid_out; endsequence
  logic rem;
  assign rem = chan_q == 3'h5 || chan_q == 3'h7;

  chk_read_answer: assert property (rd_s |-> ans_s)
    else $error("read not answered");
  chk_answer_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("answer without read");
  chk_frac_low: assert property (reg_rvalid_out && $past(reg_addr_in) == 8'h77
    |-> reg_rdata_out[1:0] == 2'h0)
    else $error("fraction low bits set");
  chk_bypass_follow: assert property (reg_wr_in && reg_addr_in == 8'h73
    |-> ##2 attn_bypass_out == $past(reg_wdata_in[5], 2))
    else $error("bypass not following");
  chk_start_pulse: assert property (adc_start_out |=> !adc_start_out)
    else $error("start longer than a cycle");
  chk_volt_period: assert property (adc_start_out && armed_q && !rem
    |-> gap_q == CONV_CYCLES + 1)
    else $error("voltage slot length wrong");
  chk_remote_period: assert property (adc_start_out && armed_q && rem
    |-> gap_q == REMOTE_SLOT_CYCLES + 1)
    else $error("remote slot length wrong");
  chk_single_chan: assert property (adc_start_out && armed_q && single_q
    |-> adc_chan_out == sel_q)
    else $error("single mode channel wrong");
endmodule : aot_readout_asserts

bind aot_readout aot_readout_asserts #(
  .CONV_CYCLES(CONV_CYCLES), .REMOTE_SLOT_CYCLES(REMOTE_SLOT_CYCLES)
) u_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .adc_start_out(adc_start_out), .adc_chan_out(adc_chan_out),
  .attn_bypass_out(attn_bypass_out)
);
`default_nettype wire

//--- test/aot_readout_tb.sv
// Purpose: Register-level bench of the readout block.
// Assumes: Slot parameters of 20 and 30, giving slots of 21 and 31 cycles.
// Notes: Converter answers each start with base +/- 4.
`timescale 1ns/1ns
`default_nettype none

module aot_readout_tb
  import aot_pkg::*;
;
  logic clk_in, resetn_in, reg_wr_in, reg_rd_in, adc_valid_in, tog;
  logic reg_rvalid_out, adc_start_out, attn_bypass_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, v, w;
  logic [2:0] adc_chan_out;
  logic [9:0] adc_data_in;
  logic [9:0] base [8];
  int bad_count, check_count;

  aot_readout #(.CONV_CYCLES(20), .REMOTE_SLOT_CYCLES(30)) uut (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .adc_start_out(adc_start_out), .adc_chan_out(adc_chan_out),
    .attn_bypass_out(attn_bypass_out), .adc_valid_in(adc_valid_in),
    .adc_data_in(adc_data_in)
  );

  // ========
  // Clock and converter
  initial begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end
  // Alternating samples: a mean differs from any single sample
  // One process owns the converter signals, so each has a single driver
  initial begin
    {adc_valid_in, tog, adc_data_in} = 12'h000;
    forever begin
      @(negedge clk_in);
      adc_valid_in <= adc_start_out;
      if (adc_start_out) begin
        tog <= ~tog;
        adc_data_in <= tog ? base[adc_chan_out] + 10'h004 : base[adc_chan_out] - 10'h004;
      end
    end
  end

  // ========
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Writes land just after a start, so no sample straddles the restart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    while (!adc_start_out) @(negedge clk_in);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    @(negedge clk_in);
    reg_wr_in = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    @(negedge clk_in);
    reg_rd_in = 1'h0;
    d = reg_rvalid_out ? reg_rdata_out : 8'hxx;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rc
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wait_n
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // Watchdog, well beyond the roughly 5000 cycles of the run
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    close_out;
  end

  // ========
  // Scenarios
  initial begin
    resetn_in = 1'h0;
    {reg_wr_in, reg_rd_in} = 2'h0;
    {reg_addr_in, reg_wdata_in} = 16'h0000;
    bad_count = 0;
    check_count = 0;
    foreach (base[i]) base[i] = 10'h100;
    base[0] = 10'h300;
    base[2] = 10'h200;
    base[5] = 10'h399;
    base[6] = 10'h066;
    base[7] = 10'h0CB;
    wait_n(20);
    resetn_in = 1'h1;
    // Reset values; fraction first, then all three to release it
    rc(8'h73, 8'h00);
    rc(8'h55, 8'hFF);
    rc(8'h20, 8'h00);
    rc(8'h40, 8'h00);
    rc(8'h77, 8'h00);
    rc(8'h25, 8'h80);
    rc(8'h26, 8'h80);
    rc(8'h27, 8'h80);
    // One round robin of averaged results
    wait_n(2200);
    rc(8'h20, 8'hC0);
    rc(8'h22, 8'h80);
    rc(8'h77, 8'hE4);
    rc(8'h25, 8'hE6);
    rc(8'h26, 8'h19);
    rc(8'h27, 8'h32);
    // Freeze holds old bytes; parked result lands on release
    rc(8'h77, 8'hE4);
    base[6] = 10'h000;
    wait_n(2200);
    rc(8'h26, 8'h19);
    rc(8'h25, 8'hE6);
    rc(8'h27, 8'h32);
    wait_n(4);
    rc(8'h26, 8'h00);
    rc(8'h77, 8'hC4);
    rc(8'h27, 8'h32);
    rc(8'h25, 8'hE6);
    rc(8'h26, 8'h00);
    // Attenuator bypass
    wr(8'h73, 8'h20);
    rc(8'h73, 8'h20);
    check({7'h00, attn_bypass_out}, 8'h01);
    // Single channel, averaging off: supply then 2.5 V input
    base[2] = 10'h100;
    wr(8'h55, 8'h40);
    wr(8'h73, 8'h50);
    wait_n(100);
    check({5'h00, adc_chan_out}, 8'h02);
    rd(8'h22, v);
    check({7'h00, v === 8'h3F || v === 8'h41}, 8'h01);
    wr(8'h55, 8'h00);
    wait_n(100);
    check({5'h00, adc_chan_out}, 8'h00);
    rd(8'h20, v);
    check({7'h00, v === 8'hBF || v === 8'hC1}, 8'h01);
    // Reserved code stores nothing
    wr(8'h55, 8'h20);
    rd(8'h20, v);
    rd(8'h22, w);
    base[0] = 10'h000;
    base[2] = 10'h000;
    wait_n(200);
    check({5'h00, adc_chan_out}, 8'h01);
    rc(8'h20, v);
    rc(8'h22, w);
    close_out;
  end
endmodule : aot_readout_tb
`default_nettype wire
